// file: design/sserp_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`default_nettype none

module sserp_fifo
  import sserp_pkg::*;
#(
  parameter int WIDTH = SSERP_EVT_W,
  parameter int DEPTH = SSERP_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr_ptr;
    logic [PW:0]                 rd_ptr;
  } sserp_fifo_state_t;

  sserp_fifo_state_t q_reg;
  sserp_fifo_state_t q_next;
  logic              full;
  logic              empty;

  // ==========================================================================
  // Flags
  assign empty     = (q_reg.wr_ptr == q_reg.rd_ptr);
  assign full      = (q_reg.wr_ptr[PW-1:0] == q_reg.rd_ptr[PW-1:0]) && (q_reg.wr_ptr[PW] != q_reg.rd_ptr[PW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = q_reg.mem[q_reg.rd_ptr[PW-1:0]];

  // ==========================================================================
  // Next state
  always_comb begin
    q_next = q_reg;
    if (in_valid && !full) begin
      q_next.mem[q_reg.wr_ptr[PW-1:0]] = in_data;
      q_next.wr_ptr = q_reg.wr_ptr + (PW+1)'(1);
    end
    if (out_ready && !empty) begin
      q_next.rd_ptr = q_reg.rd_ptr + (PW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

endmodule // sserp_fifo

`default_nettype wire

// file: design/sserp_pkg.sv
// Shared constants, types and helpers of the synthesizer serial register port
`default_nettype none

package sserp_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int SSERP_ADDR_W    = 7;
  localparam int SSERP_DATA_W    = 8;
  localparam int SSERP_IDX_W     = 4;
  localparam int SSERP_REG_COUNT = 15;
  localparam int SSERP_STATUS_W  = 6;
  localparam int SSERP_EVT_W     = SSERP_IDX_W + SSERP_DATA_W;
  localparam int SSERP_FIFO_DEPTH = 16;

  // ==========================================================================
  // Addresses and frame positions
  localparam logic [6:0] SSERP_STATUS_ADDR = 7'h00;
  localparam logic [6:0] SSERP_ID_ADDR     = 7'h0e;
  localparam logic [6:0] SSERP_LAST_ADDR   = 7'h0e;
  localparam logic [2:0] SSERP_LAST_BIT    = 3'h7;
  localparam logic       SSERP_RW_READ     = 1'h1;

  // ==========================================================================
  // Register values after reset, index 14 down to 0
  localparam logic [14:0][7:0] SSERP_REG_RESET = {
    8'h00, 8'he4, 8'h4f, 8'hf9, 8'hf0, 8'h3f, 8'hff, 8'hfa,
    8'h08, 8'h11, 8'h47, 8'h3e, 8'h06, 8'h04, 8'h00
  };

  // ==========================================================================
  // Frame phases
  typedef enum logic [1:0] {
    SSERP_PH_CMD   = 2'b00,
    SSERP_PH_WRITE = 2'b01,
    SSERP_PH_READ  = 2'b10
  } sserp_phase_t;

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] sserp_next_addr(input logic [6:0] a);
    if (a >= SSERP_LAST_ADDR) begin
      return 7'h00;
    end
    return a + 7'h01;
  endfunction

  function automatic logic sserp_writable(input logic [6:0] a);
    return (a != SSERP_STATUS_ADDR) && (a < SSERP_ID_ADDR);
  endfunction

endpackage

`default_nettype wire

// file: design/sserp_port.sv
// Serial register port of the synthesizer: link logic, crossing and update stream
`default_nettype none

module sserp_port
  import sserp_pkg::*;
#(
  parameter logic [7:0] ID_VALUE   = 8'h5a, // Arbitrary identification value
  parameter int         FIFO_DEPTH = SSERP_FIFO_DEPTH
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      sdi,
  output var  logic                      sdo,
  output var  logic                      sdo_oe,
  input  wire logic [SSERP_STATUS_W-1:0] status_flags,
  output var  logic                      cfg_valid,
  input  wire logic                      cfg_ready,
  output var  logic [SSERP_IDX_W-1:0]    cfg_addr,
  output var  logic [SSERP_DATA_W-1:0]   cfg_data
);

  // ==========================================================================
  // State types
  typedef struct packed {
    sserp_phase_t               phase;
    logic [2:0]                 bit_cnt;
    logic [6:0]                 shift;
    logic [6:0]                 ptr;
    logic [SSERP_STATUS_W-1:0]  st_s1;
    logic [SSERP_STATUS_W-1:0]  st_s2;
  } sserp_link_t;

  typedef struct packed {
    logic                       tog;
    logic [SSERP_EVT_W-1:0]     word;
  } sserp_evt_t;

  typedef struct packed {
    logic [7:0]                 sh;
    logic                       oe;
  } sserp_out_t;

  typedef struct packed {
    logic                       rst_link;
    logic                       tog_s1;
    logic                       tog_s2;
    logic                       tog_s3;
    logic                       pend_valid;
    logic [SSERP_EVT_W-1:0]     pend_word;
    logic                       cfg_valid;
    logic [SSERP_EVT_W-1:0]     cfg_word;
  } sserp_core_t;

  // ==========================================================================
  // Values after reset
  localparam sserp_link_t LINK_RESET = '{
    phase:   SSERP_PH_CMD,
    bit_cnt: 3'h0,
    shift:   7'h00,
    ptr:     7'h00,
    st_s1:   '0,
    st_s2:   '0
  };
  localparam sserp_evt_t  EVT_RESET  = '{
    tog:  1'h0,
    word: '0
  };
  localparam sserp_out_t  OUT_RESET  = '{
    sh: 8'h00,
    oe: 1'h0
  };
  localparam sserp_core_t CORE_RESET = '{
    rst_link:   1'h1,
    tog_s1:     1'h0,
    tog_s2:     1'h0,
    tog_s3:     1'h0,
    pend_valid: 1'h0,
    pend_word:  '0,
    cfg_valid:  1'h0,
    cfg_word:   '0
  };

  // ==========================================================================
  // State registers
  sserp_link_t link_reg;
  sserp_link_t link_next;
  sserp_evt_t  evt_reg;
  sserp_evt_t  evt_next;
  sserp_out_t  out_reg;
  sserp_out_t  out_next;
  sserp_core_t core_reg;
  sserp_core_t core_next;

  // ==========================================================================
  // Memory, stream and decode nets
  logic                     mem_we;
  logic [SSERP_IDX_W-1:0]   mem_waddr;
  logic [SSERP_DATA_W-1:0]  mem_wdata;
  logic [SSERP_ADDR_W-1:0]  mem_raddr;
  logic [SSERP_DATA_W-1:0]  mem_rdata;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     fifo_out_ready;
  logic [SSERP_EVT_W-1:0]   fifo_out_data;
  logic                     byte_end;
  logic                     cmd_read;
  logic                     ptr_writable;
  logic                     rd_load;
  logic                     tog_seen;

  // ==========================================================================
  // Register file on the serial clock
  sserp_regmem #(
    .ID_VALUE (ID_VALUE)
  ) u_regmem (
    .sclk   (sclk),
    .rst    (core_reg.rst_link),
    .we     (mem_we),
    .waddr  (mem_waddr),
    .wdata  (mem_wdata),
    .raddr  (mem_raddr),
    .status (link_reg.st_s2),
    .rdata  (mem_rdata)
  );

  // ==========================================================================
  // Link frame logic, cleared while chip select is high
  assign byte_end     = (link_reg.bit_cnt == SSERP_LAST_BIT);
  assign cmd_read     = (sdi == SSERP_RW_READ);
  assign ptr_writable = sserp_writable(link_reg.ptr);

  always_comb begin
    link_next         = link_reg;
    link_next.st_s1   = status_flags;
    link_next.st_s2   = link_reg.st_s1;
    link_next.bit_cnt = link_reg.bit_cnt + 3'h1;
    link_next.shift   = {link_reg.shift[5:0], sdi};
    mem_we            = 1'h0;
    mem_waddr         = link_reg.ptr[SSERP_IDX_W-1:0];
    mem_wdata         = {link_reg.shift, sdi};
    mem_raddr         = sserp_next_addr(link_reg.ptr);
    evt_next          = evt_reg;
    case (link_reg.phase)
      SSERP_PH_CMD: begin
        mem_raddr = link_reg.shift;
        if (byte_end) begin
          link_next.ptr = link_reg.shift;
          if (cmd_read) begin
            link_next.phase = SSERP_PH_READ;
          end else begin
            link_next.phase = SSERP_PH_WRITE;
          end
        end
      end
      SSERP_PH_WRITE: begin
        if (byte_end) begin
          // Commit only on the eighth bit of a complete byte
          mem_we        = ptr_writable;
          link_next.ptr = sserp_next_addr(link_reg.ptr);
          if (ptr_writable) begin
            evt_next.tog  = !evt_reg.tog;
            evt_next.word = {link_reg.ptr[SSERP_IDX_W-1:0], link_reg.shift, sdi};
          end
        end
      end
      SSERP_PH_READ: begin
        link_next.shift = link_reg.shift;
        if (byte_end) begin
          link_next.ptr = sserp_next_addr(link_reg.ptr);
        end
      end
      default: begin
        link_next.phase = SSERP_PH_CMD;
      end
    endcase
  end

  // ==========================================================================
  // Frame state, cleared while chip select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      link_reg <= LINK_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  // ==========================================================================
  // Write event toggle on the serial clock
  always_ff @(posedge sclk or posedge core_reg.rst_link) begin
    if (core_reg.rst_link) begin
      evt_reg <= EVT_RESET;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // ==========================================================================
  // Read data shifter on the falling edge
  assign rd_load = (link_reg.phase == SSERP_PH_READ) && (link_reg.bit_cnt == 3'h0);

  always_comb begin
    out_next = out_reg;
    if (rd_load) begin
      out_next.sh = mem_rdata;
      out_next.oe = 1'h1;
    end else if (out_reg.oe) begin
      out_next.sh = {out_reg.sh[6:0], 1'h0};
    end else begin
      out_next.sh = 8'h00;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_reg <= OUT_RESET;
    end else begin
      out_reg <= out_next;
    end
  end

  // ==========================================================================
  // Serial data out
  assign sdo    = out_reg.sh[7];
  assign sdo_oe = out_reg.oe;

  // ==========================================================================
  // Update stream toward the synthesizer core
  sserp_fifo #(
    .WIDTH (SSERP_EVT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (core_reg.pend_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (core_reg.pend_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !core_reg.cfg_valid || cfg_ready;

  // ==========================================================================
  // Write toggle crossing and core register stage
  assign tog_seen       = (core_reg.tog_s2 != core_reg.tog_s3);

  always_comb begin
    core_next          = core_reg;
    core_next.rst_link = reset;
    core_next.tog_s1   = evt_reg.tog;
    core_next.tog_s2   = core_reg.tog_s1;
    core_next.tog_s3   = core_reg.tog_s2;
    if (core_reg.pend_valid && fifo_in_ready) begin
      core_next.pend_valid = 1'h0;
    end
    // A new write event wins over the hand-off of the previous one
    if (tog_seen) begin
      core_next.pend_valid = 1'h1;
      core_next.pend_word  = evt_reg.word;
    end
    if (fifo_out_ready) begin
      core_next.cfg_valid = fifo_out_valid;
      core_next.cfg_word  = fifo_out_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      core_reg <= CORE_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // ==========================================================================
  // Update outputs
  assign cfg_valid = core_reg.cfg_valid;
  assign cfg_addr  = core_reg.cfg_word[SSERP_EVT_W-1:SSERP_DATA_W];
  assign cfg_data  = core_reg.cfg_word[SSERP_DATA_W-1:0];

endmodule // sserp_port

`default_nettype wire

// file: design/sserp_regmem.sv
// Fifteen byte register file on the serial clock with registered read data
`default_nettype none

module sserp_regmem
  import sserp_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'h5a
) (
  input  wire logic                      sclk,
  input  wire logic                      rst,
  input  wire logic                      we,
  input  wire logic [SSERP_IDX_W-1:0]    waddr,
  input  wire logic [SSERP_DATA_W-1:0]   wdata,
  input  wire logic [SSERP_ADDR_W-1:0]   raddr,
  input  wire logic [SSERP_STATUS_W-1:0] status,
  output var  logic [SSERP_DATA_W-1:0]   rdata
);

  typedef struct packed {
    logic [14:0][7:0] regs;
    logic [7:0]       rdata;
  } sserp_mem_state_t;

  sserp_mem_state_t q_reg;
  sserp_mem_state_t q_next;

  assign rdata = q_reg.rdata;

  // ==========================================================================
  // Write and read
  always_comb begin
    q_next = q_reg;
    if (we) begin
      q_next.regs[waddr] = wdata;
    end
    if (raddr == SSERP_STATUS_ADDR) begin
      q_next.rdata = {2'h0, status};
    end else if (raddr == SSERP_ID_ADDR) begin
      q_next.rdata = ID_VALUE;
    end else if (raddr < SSERP_LAST_ADDR) begin
      q_next.rdata = q_reg.regs[raddr[SSERP_IDX_W-1:0]];
    end else begin
      q_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      q_reg <= {SSERP_REG_RESET, 8'h00};
    end else begin
      q_reg <= q_next;
    end
  end

endmodule // sserp_regmem

`default_nettype wire

// file: testbench/sserp_checker.sv
// Assertion checker for the register port
`default_nettype none
module sserp_checker
  import sserp_pkg::*;
#(
  parameter logic [7:0] ID_VALUE   = 8'h5a,
  parameter int         FIFO_DEPTH = 16
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        sdi,
  input wire logic        sdo,
  input wire logic        sdo_oe,
  input wire logic [5:0]  status_flags,
  input wire logic        cfg_valid,
  input wire logic        cfg_ready,
  input wire logic [3:0]  cfg_addr,
  input wire logic [7:0]  cfg_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_reg;
  logic [7:0] cmd_reg;
  // ==========================================================
  // Frame bit counter and command capture
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      cnt_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end else begin
      cnt_reg <= (cnt_reg == 8'hff) ? cnt_reg : cnt_reg + 8'h01;
      if (cnt_reg < 8'h08) begin
        cmd_reg <= {cmd_reg[6:0], sdi};
      end
    end
  end
  // ==========================================================
  // Properties
  oe_idle_a: assert property (@(posedge clk) disable iff (reset) cs_n |-> !sdo_oe)
    else $error("sdo enabled while deselected");
  oe_cmd_a: assert property (@(posedge sclk) disable iff (cs_n) cnt_reg < 8'h08 |-> !sdo_oe)
    else $error("sdo enabled during command");
  oe_read_a: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_reg >= 8'h08 |-> sdo_oe == cmd_reg[0]) else $error("sdo enable wrong for direction");
  oe_steady_a: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_reg >= 8'h09 |-> $stable(sdo_oe)) else $error("sdo enable moved mid read");
  id_msb_a: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_reg == 8'h08 && cmd_reg == {SSERP_ID_ADDR, 1'b1} |-> sdo == ID_VALUE[7])
    else $error("id byte msb wrong");
  status_top_a: assert property (@(posedge sclk) disable iff (cs_n)
    cnt_reg inside {8'h08, 8'h09} && cmd_reg == 8'h01 |-> !sdo) else $error("status top bits set");
  cfg_hold_a: assert property (@(posedge clk) disable iff (reset)
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_addr) && $stable(cfg_data))
    else $error("update changed before acceptance");
  cfg_index_a: assert property (@(posedge clk) disable iff (reset)
    cfg_valid |-> cfg_addr inside {[4'h1:4'hd]}) else $error("update to read-only index");
  cfg_drop_a: assert property (@(posedge clk) disable iff (reset)
    $fell(cfg_valid) |-> $past(cfg_ready)) else $error("update dropped unaccepted");
endmodule // sserp_checker

bind sserp_port sserp_checker #(.ID_VALUE(ID_VALUE), .FIFO_DEPTH(FIFO_DEPTH)) u_checker (
  .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .status_flags(status_flags), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
  .cfg_addr(cfg_addr), .cfg_data(cfg_data));
`default_nettype wire

// file: testbench/sserp_master.sv
// Serial bus master model for the register port
`default_nettype none
module sserp_master (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdi,
  input  wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    #1 cs_n = 1'b1; // Late first edge clears the frame logic
  end
  // ==========================================================
  // One frame: n bytes, last byte cut to keep bits
  task automatic xfer(input int n, input int keep, input int slow,
                      input logic [7:0] tx [18], output logic [7:0] rx [18]);
    cs_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= ((b == n - 1) ? 8 - keep : 0); i--) begin
        sdi = tx[b][i];
        #3 sclk = 1'b1;
        rx[b][i] = sdo_line;
        #3 sclk = 1'b0;
      end
      #(3 * slow);
    end
    #3 cs_n = 1'b1;
    sdi = ~sdi;
    #20;
  endtask
  // ==========================================================
  // Clock and data toggling while deselected
  task automatic stray(input int n);
    repeat (n) begin
      sdi = 1'($urandom);
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask
endmodule // sserp_master
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking testbench of the serial register port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sserp_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identification value
  logic        clk = 1'b0;
  logic        reset, sclk, cs_n, sdi, sdo, sdo_oe, sdo_line, cfg_valid, cfg_ready, run;
  logic [5:0]  status_flags;
  logic [3:0]  cfg_addr;
  logic [7:0]  cfg_data;
  logic [7:0]  regs [15];
  logic [7:0]  tx [18];
  logic [7:0]  rx [18];
  logic [11:0] exp_q [$];
  int          err_total, checks_done;
  assign sdo_line = sdo_oe ? sdo : 1'b0;
  sserp_port #(.ID_VALUE(ID), .FIFO_DEPTH(16)) uut (.clk(clk), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .status_flags(status_flags),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_addr(cfg_addr), .cfg_data(cfg_data));
  sserp_master u_master (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));
  always #5 clk = ~clk;
  always @(negedge clk) begin
    cfg_ready <= run && ($urandom % 2 == 1);
  end
  // ==========================================================
  // Comparison, expectation and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] p);
    if (p > 8'h0e) return 8'h00;
    if (p == 8'h00) return {2'b00, status_flags};
    if (p == 8'h0e) return ID;
    return regs[p];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
      check({4'h0, cfg_addr, cfg_data}, exp_q.size() > 0 ? {4'h0, exp_q.pop_front()} : 16'hffff);
    end
  end
  // ==========================================================
  // Bursts
  task automatic wr(input logic [7:0] a, input int n, input int keep);
    logic [7:0] p;
    p = a;
    tx[0] = {a[6:0], 1'b0};
    for (int k = 1; k <= n; k++) begin
      tx[k] = 8'($urandom);
      if (p >= 8'h01 && p <= 8'h0d && (k < n || keep == 8)) begin
        regs[p] = tx[k];
        exp_q.push_back({p[3:0], tx[k]});
      end
      p = (p >= 8'h0e) ? 8'h00 : p + 8'h01;
    end
    u_master.xfer(n + 1, keep, $urandom % 2, tx, rx);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] p;
    p = a;
    tx[0] = {a[6:0], 1'b1};
    for (int k = 1; k <= n; k++) begin
      tx[k] = 8'($urandom);
    end
    u_master.xfer(n + 1, 8, 0, tx, rx);
    for (int k = 1; k <= n; k++) begin
      check({8'h00, rx[k]}, {8'h00, exp_byte(p)});
      p = (p >= 8'h0e) ? 8'h00 : p + 8'h01;
    end
    check({15'h0, sdo_oe}, 16'h0000);
  endtask
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'h05bf));
    reset = 1'b1;
    run = 1'b0;
    err_total = 0;
    checks_done = 0;
    status_flags = 6'($urandom);
    for (int i = 0; i < 15; i++) begin
      regs[i] = SSERP_REG_RESET[i];
    end
    repeat (2) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    repeat (4) @(negedge clk);
    run = 1'b1;
    rd(8'h00, 16);
    $display("test reset map done");
    u_master.stray(20);
    rd(8'h0d, 3);
    for (int t = 0; t < 12; t++) begin
      wr(t < 2 ? 8'h0d - 8'(t) : 8'($urandom % 15), 1 + $urandom % 4, 8);
      rd(8'($urandom % 15), 4);
    end
    $display("test random bursts done");
    wr(8'h05, 2, 5);
    wr(8'h70, 2, 8);
    wr(8'h00, 2, 8);
    wr(8'h0e, 1, 8);
    rd(8'h00, 16);
    rd(8'h0e, 2);
    rd(8'h70, 2);
    $display("test refused writes done");
    run = 1'b0;
    wr(8'h01, 15, 8);
    repeat (60) @(negedge clk);
    check({15'h0, cfg_valid}, 16'h0001);
    run = 1'b1;
    for (int i = 0; i < 500 && exp_q.size() > 0; i++) begin
      @(negedge clk);
    end
    check(16'(exp_q.size()), 16'h0000);
    rd(8'h01, 13);
    $display("test stalled stream done");
    report_and_stop();
  end
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
